// File: shared/conv_clock_pkg.sv
package conv_clock_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [15:0] OFS_TX_CONVERTER_POWER_DOWN = 16'h0090;
  localparam logic [15:0] OFS_ANALOG_CLOCK_CONTROL = 16'h0091;
  localparam logic [15:0] OFS_CLOCK_DUTY_TRIM = 16'h0092;
  localparam logic [15:0] OFS_SYNTH_OUTPUT_DIVIDER = 16'h0093;
  localparam logic [15:0] OFS_SYNTH_BYPASS_CONTROL = 16'h0094;
  localparam logic [15:0] OFS_FRAME_BOUNDARY_COARSE_DELAY = 16'h00B0;
  localparam logic [15:0] OFS_FRAME_BOUNDARY_FINE_DELAY = 16'h00B1;
  localparam logic [15:0] OFS_BOUNDARY_DELAY_STATUS_LOW = 16'h00B2;
  localparam logic [15:0] OFS_BOUNDARY_DELAY_STATUS_HIGH = 16'h00B3;
  localparam logic [15:0] OFS_SYNC_EDGE_SKIP_COUNT = 16'h00B4;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_RECEIVER_OFF = 0;
  localparam int BIT_TX_DIGITAL_CLOCK_OFF = 3;
  localparam int BIT_DUTY_AT_HALF = 4;
  localparam int BIT_DUTY_ABOVE_HALF = 5;
  localparam int BIT_BYPASS = 0;
  localparam int BIT_AUTO_OFF_ON_BYPASS = 4;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [3:0] RST_CHANNEL_POWER_OFF = 4'hF;
  localparam logic [3:0] RST_POWER_DOWN_RESERVED = 4'hF;
  localparam logic RST_RECEIVER_OFF = 1'b1;
  localparam logic [3:0] RST_DUTY_TRIM = 4'h0;
  localparam logic [1:0] RST_DIVIDE_SELECT = 2'h0;
  localparam logic RST_BYPASS = 1'b0;
  localparam logic RST_AUTO_OFF_ON_BYPASS = 1'b1;
  localparam logic [4:0] RST_COARSE_DELAY = 5'h00;
  localparam logic [7:0] RST_FINE_DELAY = 8'h00;
  localparam logic [7:0] RST_SKIP_COUNT = 8'h00;
  localparam logic [11:0] RST_MEASURED = 12'h000;

  // ----------------------------------------
  // counts
  // ----------------------------------------
  localparam logic [11:0] MEASURE_LIMIT = 12'hFFF;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b01,
    SEQ_HOLD = 2'b10
  } seq_state_t;

endpackage

// File: rtl/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int WIDTH = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t cur;
  sync_state_t next_cur;

  // a change counts only once stages two and three agree
  always_comb
  begin
    next_cur = cur;
    next_cur.s1 = pin;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (cur.s2[i] == cur.s3[i])
      begin
        next_cur.level[i] = cur.s3[i];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign level = cur.level;

endmodule

// File: rtl/boundary_delay_meter.sv
`timescale 1ns/1ps
module boundary_delay_meter (
  input wire logic clk,
  input wire logic srst,
  input wire logic sysref_edge,
  input wire logic boundary,
  input wire logic arm,
  input wire logic [7:0] skip_count,
  output logic sync_pulse,
  output logic [11:0] measured
);

  typedef struct packed {
    logic [11:0] since_boundary;
    logic [7:0] remaining;
    logic [11:0] measured;
    logic sync_pulse;
  } meter_state_t;

  meter_state_t cur;
  meter_state_t next_cur;

  always_comb
  begin
    next_cur = cur;
    next_cur.sync_pulse = 1'b0;
    // saturate rather than wrap so a missing boundary reads as out of range
    if (boundary)
    begin
      next_cur.since_boundary = 12'h000;
    end
    else if (cur.since_boundary != conv_clock_pkg::MEASURE_LIMIT)
    begin
      next_cur.since_boundary = cur.since_boundary + 12'h001;
    end
    if (arm)
    begin
      next_cur.remaining = skip_count; // [R10]
    end
    else if (sysref_edge)
    begin
      if (cur.remaining != 8'h00)
      begin
        next_cur.remaining = cur.remaining - 8'h01; // [R10]
      end
      else
      begin
        next_cur.sync_pulse = 1'b1;
        next_cur.measured = cur.since_boundary; // [R9]
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign sync_pulse = cur.sync_pulse;
  assign measured = cur.measured;

  a_skip_ignores_edge: assert property (@(posedge clk) disable iff (srst) // [R10]
    (sysref_edge && !arm && cur.remaining != 8'h00) |=>
      (!sync_pulse && cur.remaining == $past(cur.remaining) - 8'h01))
    else $error("counted edge produced a sync");

  a_sync_captures_delay: assert property (@(posedge clk) disable iff (srst) // [R9]
    (sysref_edge && !arm && cur.remaining == 8'h00) |=>
      (sync_pulse && measured == $past(cur.since_boundary)))
    else $error("sync edge did not capture the delay");

endmodule

// File: rtl/converter_clock_sync_regs.sv
// Functional notes
// R1: bit set powers down analog clock receiver
// R2: read-only flags: duty above half, at half
// R3: four-bit duty trim code, resets to zero
// R4: divider code n divides by n plus one
// R5: bypass bit selects direct clock over synthesizer
// R6: auto power-off of synthesizer while bypassed
// R7: five-bit coarse boundary delay in frames
// R8: eight-bit fine boundary delay in cycles
// R9: twelve-bit measured delay, split over two registers
// R10: ignore programmed number of sync edges first
// R11: non-zero skip count enables pulse counting
// R12: one-shot sync uses tx clock-off and swap
// R13: each channel bit powers down its converter
`timescale 1ns/1ps
module converter_clock_sync_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic duty_above_half_in,
  input wire logic duty_at_half_in,
  input wire logic sysref_in,
  input wire logic sync_swap_control,
  input wire logic lmfc_boundary,
  output logic channel0_power_off,
  output logic channel1_power_off,
  output logic channel2_power_off,
  output logic channel3_power_off,
  output logic clock_receiver_off,
  output logic [3:0] duty_trim_code,
  output logic [1:0] synth_divide_select,
  output logic synth_bypass,
  output logic synth_power_off,
  output logic converter_clk_en,
  output logic [4:0] boundary_coarse_delay,
  output logic [7:0] boundary_fine_delay,
  output logic pulse_count_mode,
  output logic tx_digital_clock_off,
  output logic sync_pulse
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] channel_off;
    logic receiver_off;
    logic [3:0] trim;
    logic [1:0] divide;
    logic bypass;
    logic auto_off;
    logic synth_off;
    logic [4:0] coarse;
    logic [7:0] fine;
    logic [7:0] skip;
    logic [7:0] rdata;
    logic [1:0] div_cnt;
    logic clk_en;
    logic swap_prev;
    logic sysref_prev;
    conv_clock_pkg::seq_state_t seq;
  } regs_state_t;

  regs_state_t cur;
  regs_state_t next_cur;

  logic [2:0] pin_level;
  logic sysref_level;
  logic above_half;
  logic at_half;
  logic sysref_edge;
  logic swap_rise;
  logic [11:0] measured;

  function automatic logic hit(input logic [15:0] addr, input logic [15:0] ofs);
    hit = (addr == ofs);
  endfunction

  // ----------------------------------------
  // pin inputs
  // ----------------------------------------
  pin_sync3 #(
    .WIDTH(3)
  ) u_pins (
    .clk(clk),
    .srst(srst),
    .pin({sysref_in, duty_above_half_in, duty_at_half_in}),
    .level(pin_level)
  );

  assign sysref_level = pin_level[2];
  assign above_half = pin_level[1];
  assign at_half = pin_level[0];
  assign sysref_edge = sysref_level && !cur.sysref_prev;
  // swap bit comes from register logic on this clock, no synchroniser
  assign swap_rise = sync_swap_control && !cur.swap_prev;

  // ----------------------------------------
  // sync edge counting and delay measure
  // ----------------------------------------
  boundary_delay_meter u_meter (
    .clk(clk),
    .srst(srst),
    .sysref_edge(sysref_edge),
    .boundary(lmfc_boundary),
    .arm(swap_rise),
    .skip_count(cur.skip),
    .sync_pulse(sync_pulse),
    .measured(measured)
  );

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  function automatic logic [7:0] read_value(input logic [15:0] addr, input regs_state_t s,
                                            input logic gt, input logic eq,
                                            input logic [11:0] meas);
    logic [7:0] v;
    v = 8'h00;
    if (hit(addr, conv_clock_pkg::OFS_TX_CONVERTER_POWER_DOWN))
    begin
      v = {conv_clock_pkg::RST_POWER_DOWN_RESERVED, s.channel_off}; // [R13]
    end
    else if (hit(addr, conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL))
    begin
      v[conv_clock_pkg::BIT_RECEIVER_OFF] = s.receiver_off;
      v[conv_clock_pkg::BIT_TX_DIGITAL_CLOCK_OFF] = (s.seq == conv_clock_pkg::SEQ_HOLD);
    end
    else if (hit(addr, conv_clock_pkg::OFS_CLOCK_DUTY_TRIM))
    begin
      v[3:0] = s.trim;
      v[conv_clock_pkg::BIT_DUTY_AT_HALF] = eq; // [R2]
      v[conv_clock_pkg::BIT_DUTY_ABOVE_HALF] = gt; // [R2]
    end
    else if (hit(addr, conv_clock_pkg::OFS_SYNTH_OUTPUT_DIVIDER))
    begin
      v[1:0] = s.divide;
    end
    else if (hit(addr, conv_clock_pkg::OFS_SYNTH_BYPASS_CONTROL))
    begin
      v[conv_clock_pkg::BIT_BYPASS] = s.bypass;
      v[conv_clock_pkg::BIT_AUTO_OFF_ON_BYPASS] = s.auto_off;
    end
    else if (hit(addr, conv_clock_pkg::OFS_FRAME_BOUNDARY_COARSE_DELAY))
    begin
      v[4:0] = s.coarse;
    end
    else if (hit(addr, conv_clock_pkg::OFS_FRAME_BOUNDARY_FINE_DELAY))
    begin
      v = s.fine;
    end
    else if (hit(addr, conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_LOW))
    begin
      v = meas[7:0]; // [R9]
    end
    else if (hit(addr, conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_HIGH))
    begin
      v[3:0] = meas[11:8]; // [R9]
    end
    else if (hit(addr, conv_clock_pkg::OFS_SYNC_EDGE_SKIP_COUNT))
    begin
      v = s.skip;
    end
    return v;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.swap_prev = sync_swap_control;
    next_cur.sysref_prev = sysref_level;
    if (reg_read)
    begin
      next_cur.rdata = read_value(reg_addr, cur, above_half, at_half, measured);
    end
    if (reg_write)
    begin
      if (hit(reg_addr, conv_clock_pkg::OFS_TX_CONVERTER_POWER_DOWN))
      begin
        next_cur.channel_off = reg_wdata[3:0]; // [R13]
      end
      if (hit(reg_addr, conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL))
      begin
        next_cur.receiver_off = reg_wdata[conv_clock_pkg::BIT_RECEIVER_OFF]; // [R1]
      end
      if (hit(reg_addr, conv_clock_pkg::OFS_CLOCK_DUTY_TRIM))
      begin
        next_cur.trim = reg_wdata[3:0]; // [R3]
      end
      if (hit(reg_addr, conv_clock_pkg::OFS_SYNTH_OUTPUT_DIVIDER))
      begin
        next_cur.divide = reg_wdata[1:0]; // [R4]
      end
      if (hit(reg_addr, conv_clock_pkg::OFS_SYNTH_BYPASS_CONTROL))
      begin
        next_cur.bypass = reg_wdata[conv_clock_pkg::BIT_BYPASS]; // [R5]
        next_cur.auto_off = reg_wdata[conv_clock_pkg::BIT_AUTO_OFF_ON_BYPASS]; // [R6]
      end
      if (hit(reg_addr, conv_clock_pkg::OFS_FRAME_BOUNDARY_COARSE_DELAY))
      begin
        next_cur.coarse = reg_wdata[4:0]; // [R7]
      end
      if (hit(reg_addr, conv_clock_pkg::OFS_FRAME_BOUNDARY_FINE_DELAY))
      begin
        next_cur.fine = reg_wdata; // [R8]
      end
      if (hit(reg_addr, conv_clock_pkg::OFS_SYNC_EDGE_SKIP_COUNT))
      begin
        next_cur.skip = reg_wdata; // [R10]
      end
    end
    // synthesizer is off only while both bits are set
    next_cur.synth_off = next_cur.bypass && next_cur.auto_off; // [R6]
    // direct clock gives an enable every cycle; else one in divide+1
    if (cur.bypass)
    begin
      next_cur.div_cnt = 2'h0; // [R5]
      next_cur.clk_en = 1'b1;
    end
    else if (cur.div_cnt >= cur.divide)
    begin
      next_cur.div_cnt = 2'h0; // [R4]
      next_cur.clk_en = 1'b1;
    end
    else
    begin
      next_cur.div_cnt = cur.div_cnt + 2'h1;
      next_cur.clk_en = 1'b0;
    end
    // one-shot sequence: tx clock held off from swap until sync lands
    case (cur.seq)
      conv_clock_pkg::SEQ_IDLE:
      begin
        if (swap_rise)
        begin
          next_cur.seq = conv_clock_pkg::SEQ_HOLD; // [R12]
        end
      end
      conv_clock_pkg::SEQ_HOLD:
      begin
        if (sync_pulse)
        begin
          next_cur.seq = conv_clock_pkg::SEQ_IDLE; // [R12]
        end
      end
      default:
      begin
        next_cur.seq = conv_clock_pkg::SEQ_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cur <= '0;
      cur.channel_off <= conv_clock_pkg::RST_CHANNEL_POWER_OFF;
      cur.receiver_off <= conv_clock_pkg::RST_RECEIVER_OFF;
      cur.trim <= conv_clock_pkg::RST_DUTY_TRIM;
      cur.divide <= conv_clock_pkg::RST_DIVIDE_SELECT;
      cur.bypass <= conv_clock_pkg::RST_BYPASS;
      cur.auto_off <= conv_clock_pkg::RST_AUTO_OFF_ON_BYPASS;
      cur.coarse <= conv_clock_pkg::RST_COARSE_DELAY;
      cur.fine <= conv_clock_pkg::RST_FINE_DELAY;
      cur.skip <= conv_clock_pkg::RST_SKIP_COUNT;
      cur.seq <= conv_clock_pkg::SEQ_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = cur.rdata;
  assign channel0_power_off = cur.channel_off[0];
  assign channel1_power_off = cur.channel_off[1];
  assign channel2_power_off = cur.channel_off[2];
  assign channel3_power_off = cur.channel_off[3];
  assign clock_receiver_off = cur.receiver_off;
  assign duty_trim_code = cur.trim;
  assign synth_divide_select = cur.divide;
  assign synth_bypass = cur.bypass;
  assign synth_power_off = cur.synth_off;
  assign converter_clk_en = cur.clk_en;
  assign boundary_coarse_delay = cur.coarse;
  assign boundary_fine_delay = cur.fine;
  assign pulse_count_mode = (cur.skip != 8'h00); // [R11]
  assign tx_digital_clock_off = (cur.seq == conv_clock_pkg::SEQ_HOLD); // [R12]

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_receiver_write: assert property (@(posedge clk) disable iff (srst) // [R1]
    (reg_write && hit(reg_addr, conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL)) |=>
      (clock_receiver_off == $past(reg_wdata[0])))
    else $error("receiver power-down bit not written");

  a_duty_flag_read: assert property (@(posedge clk) disable iff (srst) // [R2]
    (reg_read && hit(reg_addr, conv_clock_pkg::OFS_CLOCK_DUTY_TRIM)) |=>
      (reg_rdata[5:4] == $past({above_half, at_half})))
    else $error("duty flags misreported");

  a_trim_holds: assert property (@(posedge clk) disable iff (srst) // [R3]
    !(reg_write && hit(reg_addr, conv_clock_pkg::OFS_CLOCK_DUTY_TRIM)) |=>
      $stable(duty_trim_code))
    else $error("trim code changed without a write");

  a_divide_by_two: assert property (@(posedge clk) disable iff (srst) // [R4]
    (converter_clk_en && !synth_bypass && synth_divide_select == 2'h1 && !reg_write) |=>
      !converter_clk_en ##1 converter_clk_en)
    else $error("divide-by-two rate wrong");

  a_bypass_direct: assert property (@(posedge clk) disable iff (srst) // [R5]
    (synth_bypass && $past(synth_bypass)) |-> converter_clk_en)
    else $error("bypass did not give direct clock");

  a_auto_power_off: assert property (@(posedge clk) disable iff (srst) // [R6]
    (reg_write && hit(reg_addr, conv_clock_pkg::OFS_SYNTH_BYPASS_CONTROL)) |=>
      (synth_power_off == ($past(reg_wdata[0]) && $past(reg_wdata[4]))))
    else $error("synthesizer auto power-off wrong");

  a_coarse_write: assert property (@(posedge clk) disable iff (srst) // [R7]
    (reg_write && hit(reg_addr, conv_clock_pkg::OFS_FRAME_BOUNDARY_COARSE_DELAY)) |=>
      (boundary_coarse_delay == $past(reg_wdata[4:0])))
    else $error("coarse delay not written");

  a_fine_write: assert property (@(posedge clk) disable iff (srst) // [R8]
    (reg_write && hit(reg_addr, conv_clock_pkg::OFS_FRAME_BOUNDARY_FINE_DELAY)) |=>
      (boundary_fine_delay == $past(reg_wdata)))
    else $error("fine delay not written");

  a_status_high_read: assert property (@(posedge clk) disable iff (srst) // [R9]
    (reg_read && hit(reg_addr, conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_HIGH)) |=>
      (reg_rdata == {4'h0, $past(measured[11:8])}))
    else $error("measured delay high bits misreported");

  a_pulse_mode_off: assert property (@(posedge clk) disable iff (srst) // [R11]
    (reg_write && hit(reg_addr, conv_clock_pkg::OFS_SYNC_EDGE_SKIP_COUNT)) |=>
      (pulse_count_mode == ($past(reg_wdata) != 8'h00)))
    else $error("pulse counting mode wrong");

  a_tx_clock_hold: assert property (@(posedge clk) disable iff (srst) // [R12]
    (swap_rise && cur.seq == conv_clock_pkg::SEQ_IDLE) |=>
      (tx_digital_clock_off && !$past(tx_digital_clock_off)))
    else $error("tx digital clock not held off");

  a_channel_power: assert property (@(posedge clk) disable iff (srst) // [R13]
    (reg_write && hit(reg_addr, conv_clock_pkg::OFS_TX_CONVERTER_POWER_DOWN)) |=>
      ({channel3_power_off, channel2_power_off, channel1_power_off,
        channel0_power_off} == $past(reg_wdata[3:0])))
    else $error("channel power-down bits not written");

endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic duty_above_half_in = 1'b0;
  logic duty_at_half_in = 1'b0;
  logic sysref_in = 1'b0;
  logic sync_swap_control = 1'b0;
  logic lmfc_boundary = 1'b0;
  logic ch0, ch1, ch2, ch3, rx_off, byp, pll_off, clk_en, cnt_mode, tx_off, sync_pulse;
  logic [3:0] trim;
  logic [1:0] div_sel;
  logic [4:0] coarse;
  logic [7:0] fine;
  int error_cnt = 0;
  int comparisons = 0;
  int pulse_cnt = 0;

  `define CHECK(name, exp, got) \
    begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
        error_cnt++; \
        $display("FAIL %s expected %0h seen %0h", name, exp, got); \
      end \
    end

  always #10 clk = ~clk;

  always @(posedge clk)
    if (sync_pulse === 1'b1)
      pulse_cnt++;

  converter_clock_sync_regs converter_clock_sync_regs_inst (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .duty_above_half_in(duty_above_half_in), .duty_at_half_in(duty_at_half_in),
    .sysref_in(sysref_in), .sync_swap_control(sync_swap_control),
    .lmfc_boundary(lmfc_boundary), .channel0_power_off(ch0), .channel1_power_off(ch1),
    .channel2_power_off(ch2), .channel3_power_off(ch3), .clock_receiver_off(rx_off),
    .duty_trim_code(trim), .synth_divide_select(div_sel), .synth_bypass(byp),
    .synth_power_off(pll_off), .converter_clk_en(clk_en),
    .boundary_coarse_delay(coarse), .boundary_fine_delay(fine),
    .pulse_count_mode(cnt_mode), .tx_digital_clock_off(tx_off), .sync_pulse(sync_pulse)
  );

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cyc(1);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    cyc(1);
    reg_write = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    cyc(1);
    reg_addr = a;
    reg_read = 1'b1;
    cyc(1);
    reg_read = 1'b0;
    cyc(1);
    d = reg_rdata;
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHECK($sformatf("reg %0h", a), e, d)
  endtask

  // gap between two enable pulses; bounded so an enable stuck low ends the run
  task automatic period(output int p);
    int n;
    n = 0;
    while (clk_en !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    p = 1;
    cyc(1);
    while (clk_en !== 1'b1 && p < 20)
    begin
      cyc(1);
      p++;
    end
    if (p >= 20)
    begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic pulse_sysref();
    sysref_in = 1'b1;
    cyc(2);
    sysref_in = 1'b0;
    cyc(10);
  endtask

  // boundary marker, then a sysref edge k cycles later; latency offset cancels in differences
  task automatic meas(input int k, output logic [11:0] m);
    logic [7:0] lo;
    logic [7:0] hi;
    cyc(1);
    lmfc_boundary = 1'b1;
    cyc(1);
    lmfc_boundary = 1'b0;
    cyc(k - 1);
    pulse_sysref();
    rd(conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_LOW, lo);
    rd(conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_HIGH, hi);
    `CHECK("status high spare bits", 4'h0, hi[7:4])
    m = {hi[3:0], lo};
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    end_sim();
  end

  initial
  begin
    logic [7:0] wd94 [4];
    logic [7:0] rd94 [4];
    logic [11:0] m1, m2, m3;
    int p;
    int base;
    wd94 = '{8'h01, 8'h11, 8'h10, 8'hFF};
    rd94 = '{8'h01, 8'h11, 8'h10, 8'h11};
    cyc(6);
    srst = 1'b0;
    `CHECK("channel power", 4'hF, {ch3, ch2, ch1, ch0})
    `CHECK("receiver off", 1'b1, rx_off)
    `CHECK("count mode", 1'b0, cnt_mode)
    chk_rd(conv_clock_pkg::OFS_TX_CONVERTER_POWER_DOWN, 8'hFF);
    chk_rd(conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL, 8'h01);
    chk_rd(conv_clock_pkg::OFS_CLOCK_DUTY_TRIM, 8'h00);
    chk_rd(conv_clock_pkg::OFS_SYNTH_OUTPUT_DIVIDER, 8'h00);
    chk_rd(conv_clock_pkg::OFS_SYNTH_BYPASS_CONTROL,
           {3'h0, conv_clock_pkg::RST_AUTO_OFF_ON_BYPASS, 4'h0});
    for (int i = 0; i < 5; i++)
      chk_rd(16'(16'h00B0 + i), 8'h00);
    // unmapped and status places must swallow writes
    wr(16'h00A0, 8'hFF);
    chk_rd(16'h00A0, 8'h00);
    wr(conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_LOW, 8'hFF);
    wr(conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_HIGH, 8'hFF);
    chk_rd(conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_LOW, 8'h00);
    chk_rd(conv_clock_pkg::OFS_BOUNDARY_DELAY_STATUS_HIGH, 8'h00);
    for (int i = 0; i < 16; i++)
    begin
      wr(conv_clock_pkg::OFS_TX_CONVERTER_POWER_DOWN, 8'(i));
      `CHECK("channel power", i[3:0], {ch3, ch2, ch1, ch0})
      chk_rd(conv_clock_pkg::OFS_TX_CONVERTER_POWER_DOWN, {4'hF, i[3:0]});
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL, {7'h7F, b[0]});
      `CHECK("receiver off", b[0], rx_off)
      chk_rd(conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL, {7'h00, b[0]});
    end
    wr(conv_clock_pkg::OFS_CLOCK_DUTY_TRIM, 8'hFA);
    `CHECK("duty trim", 4'hA, trim)
    chk_rd(conv_clock_pkg::OFS_CLOCK_DUTY_TRIM, 8'h0A);
    duty_above_half_in = 1'b1;
    cyc(6);
    chk_rd(conv_clock_pkg::OFS_CLOCK_DUTY_TRIM, 8'h2A);
    duty_above_half_in = 1'b0;
    duty_at_half_in = 1'b1;
    cyc(6);
    chk_rd(conv_clock_pkg::OFS_CLOCK_DUTY_TRIM, 8'h1A);
    duty_at_half_in = 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wr(conv_clock_pkg::OFS_SYNTH_OUTPUT_DIVIDER, {6'h3F, c[1:0]});
      `CHECK("divide select", c[1:0], div_sel)
      chk_rd(conv_clock_pkg::OFS_SYNTH_OUTPUT_DIVIDER, {6'h00, c[1:0]});
      period(p);
      `CHECK("enable period", c + 1, p)
    end
    // divider stays at four, so bypass shows as a period of one
    for (int i = 0; i < 4; i++)
    begin
      wr(conv_clock_pkg::OFS_SYNTH_BYPASS_CONTROL, wd94[i]);
      cyc(1);
      `CHECK("bypass", rd94[i][0], byp)
      `CHECK("synth off", rd94[i][0] & rd94[i][4], pll_off)
      chk_rd(conv_clock_pkg::OFS_SYNTH_BYPASS_CONTROL, rd94[i]);
      period(p);
      `CHECK("enable period", rd94[i][0] ? 1 : 4, p)
    end
    wr(conv_clock_pkg::OFS_FRAME_BOUNDARY_COARSE_DELAY, 8'hFF);
    `CHECK("coarse delay", 5'h1F, coarse)
    chk_rd(conv_clock_pkg::OFS_FRAME_BOUNDARY_COARSE_DELAY, 8'h1F);
    wr(conv_clock_pkg::OFS_FRAME_BOUNDARY_FINE_DELAY, 8'hA5);
    `CHECK("fine delay", 8'hA5, fine)
    chk_rd(conv_clock_pkg::OFS_FRAME_BOUNDARY_FINE_DELAY, 8'hA5);
    base = pulse_cnt;
    meas(10, m1);
    meas(50, m2);
    meas(300, m3);
    `CHECK("measured step", 12'h028, 12'(m2 - m1))
    `CHECK("measured wide step", 12'h122, 12'(m3 - m1))
    `CHECK("continuous syncs", 3, pulse_cnt - base)
    // a boundary further back than the counter can hold reads as the limit
    meas(4100, m1);
    `CHECK("measured saturates", conv_clock_pkg::MEASURE_LIMIT, m1)
    wr(conv_clock_pkg::OFS_SYNC_EDGE_SKIP_COUNT, 8'h02);
    `CHECK("count mode", 1'b1, cnt_mode)
    chk_rd(conv_clock_pkg::OFS_SYNC_EDGE_SKIP_COUNT, 8'h02);
    base = pulse_cnt;
    sync_swap_control = 1'b1;
    cyc(3);
    `CHECK("tx clock off", 1'b1, tx_off)
    chk_rd(conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL, 8'h09);
    for (int j = 0; j < 3; j++)
    begin
      pulse_sysref();
      `CHECK("skipped syncs", (j == 2) ? 1 : 0, pulse_cnt - base)
      `CHECK("tx clock off", (j < 2) ? 1'b1 : 1'b0, tx_off)
    end
    sync_swap_control = 1'b0;
    chk_rd(conv_clock_pkg::OFS_ANALOG_CLOCK_CONTROL, 8'h01);
    wr(conv_clock_pkg::OFS_SYNC_EDGE_SKIP_COUNT, 8'h00);
    `CHECK("count mode", 1'b0, cnt_mode)
    end_sim();
  end

endmodule
